// ===== rtl/pwm_channel.sv
// one modulator channel: counter, double-buffered period and duty, waveform flop
`timescale 1ns/100ps
module pwm_channel (
   input  wire logic            clk,          // interface clock
   input  wire logic            resetn,       // async reset, active low
   input  wire logic            ce,           // clock enable, freezes state when low
   input  wire logic            tick,         // selected channel clock edge
   input  wire pwm_pkg::chanCfg_t cfg,        // enable, alignment, polarity
   input  wire logic [7:0]      perBuf,       // buffered period
   input  wire logic [7:0]      dutyBuf,      // buffered duty
   input  wire logic            cntWrite,     // software wrote the counter
   output logic                 wave,         // modulated output, from a flop
   output logic [7:0]           count         // live counter value
);

   // all channel state
   typedef struct packed {
      logic [7:0] cnt;       // up/down counter
      logic [7:0] perAct;    // active period latch
      logic [7:0] dutyAct;   // active duty latch
      logic       down;      // center mode direction
      logic       running;   // enable synchronised to clock
      logic       wave;      // registered output
   } chanState_t;

   chanState_t s;        // current state
   chanState_t next_s;   // next state

   // next-state logic
   always_comb begin
      next_s = s;
      // latches follow buffers while off or on a counter write
      if (!cfg.on || cntWrite) begin
         next_s.perAct  = perBuf;
         next_s.dutyAct = dutyBuf;
      end
      if (!cfg.on) begin
         next_s.running = 1'b0;   // counter holds its value while off
      end
      if (cntWrite) begin
         next_s.cnt  = 8'h00;   // any write clears, direction up
         next_s.down = 1'b0;
      end else if (cfg.on && tick) begin
         if (!s.running) begin
            next_s.running = 1'b1;   // waveform waits for the clock edge
         end else if (!cfg.center) begin
            // left aligned: 0 .. period-1
            if ({1'b0, s.cnt} + 9'h001 >= {1'b0, s.perAct}) begin
               next_s.cnt     = 8'h00;
               next_s.perAct  = perBuf;   // period end loads buffers
               next_s.dutyAct = dutyBuf;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end else if (!s.down) begin
            // center aligned: up to period, then down
            if (s.cnt >= s.perAct) begin
               next_s.down = 1'b1;
               next_s.cnt  = (s.perAct == 8'h00) ? 8'h00 : s.cnt - 8'h01;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end else if (s.cnt <= 8'h01) begin
            next_s.cnt     = 8'h00;   // back at zero: period ends
            next_s.down    = 1'b0;
            next_s.perAct  = perBuf;
            next_s.dutyAct = dutyBuf;
         end else begin
            next_s.cnt = s.cnt - 8'h01;
         end
      end
      // output: inactive while off or unsynchronised, else compare
      if (!cfg.on || !s.running) begin
         next_s.wave = ~cfg.startLevel;
      end else begin
         // polarity taken live, a change may cut one pulse
         next_s.wave = (s.cnt < s.dutyAct) ? cfg.startLevel : ~cfg.startLevel;
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign wave  = s.wave;
   assign count = s.cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !ce);

   off_level_a: assert property (!cfg.on |=> wave == !$past(cfg.startLevel))
      else $error("disabled channel not at inactive level");
   enable_sync_a: assert property ($rose(cfg.on) && !tick |=> !s.running)
      else $error("waveform released before clock edge");
   active_level_a: assert property (cfg.on && s.running && s.cnt < s.dutyAct
      |=> wave == $past(cfg.startLevel))
      else $error("wrong level before duty count");
   left_wrap_a: assert property (cfg.on && tick && s.running && !cfg.center && !cntWrite
      && ({1'b0, s.cnt} + 9'h001 >= {1'b0, s.perAct}) |=> s.cnt == 8'h00)
      else $error("left aligned counter did not wrap");
   center_turn_a: assert property (cfg.on && tick && s.running && cfg.center && !cntWrite
      && !s.down && s.cnt >= s.perAct |=> s.down)
      else $error("center counter did not turn at period");
   latch_load_a: assert property (cntWrite |=> s.perAct == $past(perBuf) && s.cnt == 8'h00)
      else $error("counter write did not load period");

endmodule

// ===== rtl/pwm_pkg.sv
// shared constants, register indices and carrier types for the two-channel modulator
package pwm_pkg;

   // register window bases, in word units of the global map
   localparam logic [9:0] BASE_BLOCKING    = 10'h200;   // accesses here stall the master
   localparam logic [9:0] BASE_NONBLOCKING = 10'h300;   // accesses here answer quickly

   // register indices within the window (byte address = 4 * (base + index))
   localparam logic [7:0] IDX_CTL   = 8'h60;   // channel_control
   localparam logic [7:0] IDX_PRCLK = 8'h61;   // prescale_select
   localparam logic [7:0] IDX_SCLA  = 8'h62;   // scale_a_value
   localparam logic [7:0] IDX_SCLB  = 8'h63;   // scale_b_value
   localparam logic [7:0] IDX_CNT0  = 8'h64;   // channel0_counter
   localparam logic [7:0] IDX_CNT1  = 8'h65;   // channel1_counter
   localparam logic [7:0] IDX_PER0  = 8'h66;   // channel0_period
   localparam logic [7:0] IDX_PER1  = 8'h67;   // channel1_period
   localparam logic [7:0] IDX_DTY0  = 8'h68;   // channel0_duty
   localparam logic [7:0] IDX_DTY1  = 8'h69;   // channel1_duty

   // field layout of prescale_select
   localparam int         PRCLK_A_LSB   = 0;       // clk_a_div_sel field
   localparam int         PRCLK_B_LSB   = 4;       // clk_b_div_sel field
   localparam logic [7:0] PRCLK_WR_MASK = 8'h77;   // bits 7 and 3 are reserved

   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;       // every register clears at reset

   // wait counts loaded when a request is taken
   localparam logic [1:0] WAIT_BLOCKING    = 2'h2;  // extra stall cycles
   localparam logic [1:0] WAIT_NONBLOCKING = 2'h0;  // no extra stall

   // shared prescaler width (divide up to 128)
   localparam int PRESCALE_W = 7;

   // bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,   // waiting for a request
      BUS_WAIT = 2'b01,   // counting stall cycles
      BUS_ACK  = 2'b10    // waitrequest low, request completes
   } busState_t;

   // channel_control layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] center_align_sel;   // per channel: 1 center, 0 left
      logic       chan1_clk_sel;      // 0 clock B, 1 clock SB
      logic       chan0_clk_sel;      // 0 clock A, 1 clock SA
      logic [1:0] start_level;        // per channel start polarity
      logic [1:0] chan_on;            // per channel enable
   } ctrl_t;

   // per-channel configuration carried to a channel
   typedef struct packed {
      logic on;           // channel enabled
      logic center;       // center aligned mode
      logic startLevel;   // level at period start
   } chanCfg_t;

endpackage

// ===== rtl/two_channel_pwm_control.sv
// two-channel modulator top: Avalon-MM register slave, prescaler, scalers, channels
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps

// Function
// - drive two channel waveform outputs
// - reserved bits read zero, writes ignored
// - two bases: blocking and non-blocking access
// - alignment bit picks left or center mode
// - channel 1 clock: B or scaled SB
// - channel 0 clock: A or scaled SA
// - polarity bit sets level at period start
// - enable bit turns its channel on
// - waveform waits for next source clock edge
// - prescaler stops while both channels off
// - polarity writable anytime, one odd pulse
// - clock select writable anytime, one odd pulse
// - clocks A, B: power-of-two interface clock divide
// - scaled clock divides by twice scale value
// - counter ranges for left and center mode
// - period and duty are double buffered
module two_channel_pwm_control (
   input  wire logic        clk,              // interface clock, 250 MHz
   input  wire logic        resetn,           // async reset, active low
   input  wire logic        ce,               // clock enable, freezes all state
   input  wire logic [11:0] avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data, low byte used
   input  wire logic [3:0]  avs_byteenable,   // byte lanes, lane 0 used
   output logic [31:0]      avs_readdata,     // read data, from a flop
   output logic             avs_waitrequest,  // stall, from a flop
   output logic             chan0_wave,       // channel 0 waveform
   output logic             chan1_wave        // channel 1 waveform
);

   // complete state of the top
   typedef struct packed {
      pwm_pkg::busState_t             st;           // bus slave state
      logic [1:0]                     waitCnt;      // stall cycles left
      logic [7:0]                     idx;          // captured register index
      logic                           hit;          // captured decode hit
      logic                           waitRequest;  // registered waitrequest
      logic [31:0]                    readData;     // registered read data
      pwm_pkg::ctrl_t                 ctl;          // channel_control
      logic [7:0]                     prclk;        // prescale_select
      logic [1:0][7:0]                scale;        // scale A and B values
      logic [1:0][7:0]                scaleCnt;     // scale down counters
      logic [1:0]                     scalePhase;   // half-period phase of SA, SB
      logic [pwm_pkg::PRESCALE_W-1:0] prescaler;    // shared prescale counter
      logic [1:0][7:0]                perBuf;       // period buffers
      logic [1:0][7:0]                dutyBuf;      // duty buffers
   } topState_t;

   topState_t s;        // current state
   topState_t next_s;   // next state

   // decode and datapath helpers
   logic [9:0]                     wordAddr;     // address in words
   logic [9:0]                     offBlk;       // offset from blocking base
   logic [9:0]                     offNb;        // offset from non-blocking base
   logic                           reqHit;       // request lands on a register
   logic                           reqBlk;       // request is blocking
   logic [7:0]                     reqIdx;       // register index of request
   logic                           wrNow;        // write takes effect this edge
   logic [7:0]                     rdByte;       // selected register value
   logic                           anyOn;        // some channel enabled
   logic [1:0]                     clkSel;       // per channel scaled select
   logic [1:0][pwm_pkg::PRESCALE_W-1:0] preMask; // prescale tick masks
   logic [1:0]                     baseTick;     // clock A, B edges
   logic [1:0]                     scaledTick;   // clock SA, SB edges
   logic [1:0]                     chanTick;     // selected channel clock edges
   logic [1:0]                     cntWrite;     // counter write pulses
   logic [1:0]                     waveVec;      // channel outputs
   logic [1:0][7:0]                cntVec;       // channel counter values
   pwm_pkg::chanCfg_t [1:0]        cfgVec;       // channel configuration

   // address decode over the two window bases
   always_comb begin
      wordAddr = avs_address[11:2];
      offBlk   = wordAddr - pwm_pkg::BASE_BLOCKING;
      offNb    = wordAddr - pwm_pkg::BASE_NONBLOCKING;
      reqHit   = 1'b0;
      reqBlk   = 1'b0;
      reqIdx   = 8'h00;
      // blocking window first, then the non-blocking one
      if (offBlk >= {2'h0, pwm_pkg::IDX_CTL} && offBlk <= {2'h0, pwm_pkg::IDX_DTY1}) begin
         reqHit = 1'b1;   // blocking window
         reqBlk = 1'b1;
         reqIdx = offBlk[7:0];
      end else if (offNb >= {2'h0, pwm_pkg::IDX_CTL} &&
                   offNb <= {2'h0, pwm_pkg::IDX_DTY1}) begin
         reqHit = 1'b1;   // non-blocking window
         reqIdx = offNb[7:0];
      end else begin
         reqHit = 1'b0;   // unmapped: answered quickly, reads zero
      end
   end

   // read multiplexer on the captured index
   always_comb begin
      rdByte = 8'h00;   // unmapped reads give zero
      if (!s.hit) begin
         rdByte = 8'h00;
      end else if (s.idx == pwm_pkg::IDX_CTL) begin
         rdByte = s.ctl;
      end else if (s.idx == pwm_pkg::IDX_PRCLK) begin
         rdByte = s.prclk & pwm_pkg::PRCLK_WR_MASK;   // reserved bits zero
      end else if (s.idx == pwm_pkg::IDX_SCLA) begin
         rdByte = s.scale[0];
      end else if (s.idx == pwm_pkg::IDX_SCLB) begin
         rdByte = s.scale[1];
      end else if (s.idx == pwm_pkg::IDX_CNT0) begin
         rdByte = cntVec[0];   // reading does not disturb the count
      end else if (s.idx == pwm_pkg::IDX_CNT1) begin
         rdByte = cntVec[1];
      end else if (s.idx == pwm_pkg::IDX_PER0) begin
         rdByte = s.perBuf[0];   // last written, not the active period
      end else if (s.idx == pwm_pkg::IDX_PER1) begin
         rdByte = s.perBuf[1];
      end else if (s.idx == pwm_pkg::IDX_DTY0) begin
         rdByte = s.dutyBuf[0];
      end else begin
         rdByte = s.dutyBuf[1];
      end
   end

   // a write lands at the edge where waitrequest is sampled low
   assign wrNow = (s.st == pwm_pkg::BUS_ACK) && avs_write && s.hit && avs_byteenable[0];
   assign anyOn = |s.ctl.chan_on;
   assign clkSel = {s.ctl.chan1_clk_sel, s.ctl.chan0_clk_sel};

   // per-channel clocking, configuration and counter-write pulses
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_chan
         // clock A from bits 2..0, clock B from bits 6..4
         assign preMask[g] = ~(7'h7F << s.prclk[pwm_pkg::PRCLK_A_LSB + 4 * g +: 3]);
         assign baseTick[g] = anyOn && ((s.prescaler & preMask[g]) == preMask[g]);
         // scaled clock: one edge per two scale expiries
         assign scaledTick[g] = baseTick[g] && (s.scaleCnt[g] == 8'h01) && s.scalePhase[g];
         // clock select read live, a change may cut one pulse
         assign chanTick[g] = clkSel[g] ? scaledTick[g] : baseTick[g];
         // alignment read live; software changes it only while off
         assign cfgVec[g] = '{on: s.ctl.chan_on[g],
                              center: s.ctl.center_align_sel[g],
                              startLevel: s.ctl.start_level[g]};
         assign cntWrite[g] = wrNow && (s.idx == pwm_pkg::IDX_CNT0 + 8'(g));

         pwm_channel u_chan (
            .clk      (clk),
            .resetn   (resetn),
            .ce       (ce),
            .tick     (chanTick[g]),
            .cfg      (cfgVec[g]),
            .perBuf   (s.perBuf[g]),
            .dutyBuf  (s.dutyBuf[g]),
            .cntWrite (cntWrite[g]),
            .wave     (waveVec[g]),
            .count    (cntVec[g])
         );
      end
   endgenerate

   // next-state logic: bus slave, registers, prescaler, scalers
   always_comb begin
      next_s = s;

      // bus slave sequencing
      case (s.st)
         pwm_pkg::BUS_IDLE: begin
            // capture decode so the read mux sees a steady index
            if (avs_read || avs_write) begin
               next_s.st      = pwm_pkg::BUS_WAIT;
               next_s.idx     = reqIdx;
               next_s.hit     = reqHit;
               // blocking accesses stall longer
               next_s.waitCnt = reqBlk ? pwm_pkg::WAIT_BLOCKING : pwm_pkg::WAIT_NONBLOCKING;
            end
         end
         pwm_pkg::BUS_WAIT: begin
            // stall counts down, then read data is loaded
            if (s.waitCnt == 2'h0) begin
               next_s.st          = pwm_pkg::BUS_ACK;
               next_s.waitRequest = 1'b0;
               next_s.readData    = {24'h000000, rdByte};   // upper bits zero
            end else begin
               next_s.waitCnt = s.waitCnt - 2'h1;
            end
         end
         pwm_pkg::BUS_ACK: begin
            // answer stands one cycle, then back to idle
            next_s.st          = pwm_pkg::BUS_IDLE;
            next_s.waitRequest = 1'b1;
            next_s.readData    = 32'h00000000;
         end
         default: begin
            // unused code returns to idle
            next_s.st          = pwm_pkg::BUS_IDLE;
            next_s.waitRequest = 1'b1;
         end
      endcase

      // register writes
      if (wrNow) begin
         if (s.idx == pwm_pkg::IDX_CTL) begin
            next_s.ctl = avs_writedata[7:0];   // all bits writable anytime
         end else if (s.idx == pwm_pkg::IDX_PRCLK) begin
            next_s.prclk = avs_writedata[7:0] & pwm_pkg::PRCLK_WR_MASK;
         end else if (s.idx == pwm_pkg::IDX_PER0 || s.idx == pwm_pkg::IDX_PER1) begin
            // buffer only; the channel latches it later
            next_s.perBuf[s.idx[0]] = avs_writedata[7:0];
         end else if (s.idx == pwm_pkg::IDX_DTY0 || s.idx == pwm_pkg::IDX_DTY1) begin
            // duty buffer, latched like the period
            next_s.dutyBuf[s.idx[0]] = avs_writedata[7:0];
         end else begin
            next_s.ctl = s.ctl;   // scales handled below, counter writes go to the channels
         end
      end

      // shared prescaler, stopped while both channels are off
      if (anyOn) begin
         next_s.prescaler = s.prescaler + 7'h01;
      end else begin
         // held at zero while idle to save power
         next_s.prescaler = 7'h00;
      end

      // scale counters; a zero scale counts as 256
      for (int i = 0; i < 2; i++) begin
         if (wrNow && s.idx == pwm_pkg::IDX_SCLA + 8'(i)) begin
            next_s.scale[i]      = avs_writedata[7:0];
            next_s.scaleCnt[i]   = avs_writedata[7:0];   // write reloads the counter
            next_s.scalePhase[i] = 1'b0;
         end else if (baseTick[i]) begin
            if (s.scaleCnt[i] == 8'h01) begin
               next_s.scaleCnt[i]   = s.scale[i];
               next_s.scalePhase[i] = ~s.scalePhase[i];
            end else begin
               next_s.scaleCnt[i] = s.scaleCnt[i] - 8'h01;
            end
         end
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s             <= '0;
         s.st          <= pwm_pkg::BUS_IDLE;
         s.waitRequest <= 1'b1;
         s.ctl         <= pwm_pkg::REG_RESET;
         s.prclk       <= pwm_pkg::REG_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign avs_readdata    = s.readData;
   assign avs_waitrequest = s.waitRequest;
   assign chan0_wave      = waveVec[0];
   assign chan1_wave      = waveVec[1];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !ce);

   // request seen while idle
   sequence reqTaken;
      s.st == pwm_pkg::BUS_IDLE && (avs_read || avs_write);
   endsequence

   // the answer after a stall
   sequence ackAfterFour;
      avs_waitrequest [*4] ##1 !avs_waitrequest;
   endsequence

   sequence ackAfterTwo;
      avs_waitrequest [*2] ##1 !avs_waitrequest;
   endsequence

   // blocking window: four stalled cycles, then the answer
   blocking_wait_a: assert property (reqTaken ##0 reqBlk |-> ackAfterFour)
      else $error("blocking access answered at wrong cycle");

   // non-blocking window and unmapped places: two stalled cycles
   nonblocking_wait_a: assert property (reqTaken ##0 !reqBlk |-> ackAfterTwo)
      else $error("non-blocking access answered at wrong cycle");

   // upper read lanes always zero
   upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");

   // reserved prescale bits read back as zero
   prclk_reserved_a: assert property (!avs_waitrequest && s.hit
      && s.idx == pwm_pkg::IDX_PRCLK |-> avs_readdata[7] == 1'b0 && avs_readdata[3] == 1'b0)
      else $error("reserved prescale bits read nonzero");

   // no channel on: the prescaler rests at zero
   prescale_stop_a: assert property (!anyOn |=> s.prescaler == 7'h00)
      else $error("prescaler ran with both channels off");

   // a control write is stored whole
   ctl_write_a: assert property (wrNow && s.idx == pwm_pkg::IDX_CTL
      |=> s.ctl == $past(avs_writedata[7:0]))
      else $error("control write not stored");

   // the stall ends after a single low cycle
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   // read data rests at zero outside the answer cycle
   data_idle_a: assert property (avs_waitrequest |-> avs_readdata == 32'h00000000)
      else $error("read data not zero while stalled");

   // reserved prescale bits never store a one
   prclk_store_a: assert property (wrNow && s.idx == pwm_pkg::IDX_PRCLK
      |=> s.prclk[7] == 1'b0 && s.prclk[3] == 1'b0)
      else $error("reserved prescale bit stored");

   // the prescaler advances each cycle while a channel runs
   prescale_run_a: assert property (anyOn
      |=> s.prescaler == $past(s.prescaler) + 7'h01)
      else $error("prescaler stalled while a channel runs");

   // select code zero gives clock A on every cycle
   clock_a_full_a: assert property (anyOn && s.prclk[2:0] == 3'h0 |-> baseTick[0])
      else $error("undivided clock A missed a cycle");

   // select code one gives clock B on odd prescaler counts
   clock_b_half_a: assert property (baseTick[1] && s.prclk[6:4] == 3'h1
      |-> s.prescaler[0])
      else $error("clock B at code one off its phase");

   // an expired scale counter with no write pending
   sequence scaleExpiry;
      baseTick[0] && s.scaleCnt[0] == 8'h01 && !(wrNow && s.idx == pwm_pkg::IDX_SCLA);
   endsequence

   // expiry reloads the scale value for the next half period
   scale_reload_a: assert property (scaleExpiry
      |=> s.scaleCnt[0] == $past(s.scale[0]))
      else $error("scale A counter did not reload");

endmodule

// ===== tb/two_channel_pwm_control_test.sv
// self-checking bench for the two-channel modulator
`timescale 1ns/100ps
module two_channel_pwm_control_test;
   localparam logic [9:0] BL = pwm_pkg::BASE_BLOCKING;     // stalling window
   localparam logic [9:0] NB = pwm_pkg::BASE_NONBLOCKING;  // quick window
   logic        clk = 1'b0;       // 250 MHz clock
   logic        resetn = 1'b0;    // reset, active low
   logic [11:0] addr = 12'h000;   // bus address
   logic        rd = 1'b0;        // read request
   logic        wr = 1'b0;        // write request
   logic [31:0] wdata = 32'h0;    // write data
   logic [31:0] rdata;            // read data
   logic        waitReq;          // slave stall
   logic        wave0;            // channel 0 waveform
   logic        wave1;            // channel 1 waveform
   int          nFail = 0;        // mismatches
   int          numChecks = 0;    // comparisons
   int          cycles = 0;       // timeout counter
   int          lat;              // answer cycle of last access
   int          hi0, hi1, up0, up1;  // high cycles and rising edges

   always #2 clk = ~clk;

   two_channel_pwm_control u_dut (.clk(clk), .resetn(resetn), .ce(1'b1),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitReq),
      .chan0_wave(wave0), .chan1_wave(wave1));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // report counts and verdict, end the run
   task automatic testDone;
      $display("checks %0d failures %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one bus access, held until waitrequest is seen low at a rising edge
   task automatic access(input logic isWr, input logic [9:0] b, input logic [7:0] i,
                         input logic [7:0] d);
      logic [9:0] w;
      w = b + {2'h0, i};
      @(posedge clk);
      addr <= {w, 2'h0};
      rd <= ~isWr;
      wr <= isWr;
      wdata <= {24'h0, d};
      lat = -1;
      do begin
         @(negedge clk);
         lat++;
      end while (waitReq !== 1'b0);
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // read a register and compare the whole word
   task automatic rdChk(input logic [9:0] b, input logic [7:0] i, input logic [7:0] e);
      access(1'b0, b, i, 8'h00);
      check(rdata, {24'h0, e});
   endtask

   // settle, then count high cycles and rising edges over n cycles
   task automatic measure(input int n);
      logic p0, p1;
      repeat (24) @(posedge clk);
      hi0 = 0;
      hi1 = 0;
      up0 = 0;
      up1 = 0;
      @(negedge clk);
      p0 = wave0;
      p1 = wave1;
      repeat (n) begin
         @(negedge clk);
         hi0 += (wave0 === 1'b1);
         hi1 += (wave1 === 1'b1);
         up0 += (wave0 === 1'b1 && p0 === 1'b0);
         up1 += (wave1 === 1'b1 && p1 === 1'b0);
         p0 = wave0;
         p1 = wave1;
      end
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         nFail++;
         testDone();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // reset values through the stalling window
      for (int i = 0; i < 10; i++) begin
         rdChk(BL, 8'h60 + 8'(i), pwm_pkg::REG_RESET);
         check(lat, 4);
      end
      $display("reset value test done");
      // readback, reserved bits, counter and unmapped place
      access(1'b1, NB, pwm_pkg::IDX_PRCLK, 8'hFF);
      check(lat, 2);
      rdChk(NB, pwm_pkg::IDX_PRCLK, 8'h77);
      for (int i = 2; i < 10; i++) begin
         access(1'b1, NB, 8'h60 + 8'(i), 8'h3C + 8'(i));
         rdChk(NB, 8'h60 + 8'(i), (i == 4 || i == 5) ? 8'h00 : 8'h3C + 8'(i));
      end
      access(1'b1, NB, 8'h70, 8'hFF);
      rdChk(NB, 8'h70, 8'h00);
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'hFC);
      rdChk(NB, pwm_pkg::IDX_CTL, 8'hFC);
      $display("register test done");
      // disabled channels rest at the inverse of their start level
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h0C);
      measure(80);
      check(hi0 + hi1, 0);
      // left aligned: ch0 clock A /1 per 4 duty 1, ch1 clock B /2 per 5 duty 2
      access(1'b1, NB, pwm_pkg::IDX_PRCLK, 8'h10);
      access(1'b1, NB, pwm_pkg::IDX_SCLA, 8'h01);
      access(1'b1, NB, pwm_pkg::IDX_PER0, 8'h04);
      access(1'b1, NB, pwm_pkg::IDX_DTY0, 8'h01);
      access(1'b1, NB, pwm_pkg::IDX_PER1, 8'h05);
      access(1'b1, NB, pwm_pkg::IDX_DTY1, 8'h02);
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h07);
      measure(80);
      check(hi0, 20);
      check(up0, 20);
      check(hi1, 48);
      check(up1, 8);
      // polarity flipped while running
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h03);
      measure(80);
      check(hi0, 60);
      // channel 0 moved to the scaled clock, then scale changed
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h13);
      measure(80);
      check(up0, 10);
      access(1'b1, NB, pwm_pkg::IDX_SCLA, 8'h02);
      measure(80);
      check(up0, 5);
      // new period on a running channel takes over at period end
      access(1'b1, NB, pwm_pkg::IDX_PER1, 8'h0A);
      measure(80);
      check(up1, 4);
      check(hi1, 64);
      $display("left aligned test done");
      // center aligned: disable first, pick mode, then enable
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h00);
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h40);
      access(1'b1, NB, pwm_pkg::IDX_CTL, 8'h41);
      measure(80);
      check(up0, 10);
      check(hi0, 70);
      check(hi1, 80);
      $display("center aligned test done");
      testDone();
   end
endmodule
